// ---- design/sar_cfg.svh ----
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// result word width and index of its most significant bit
`define SAR_WIDTH 8
`define SAR_IDX_W 3
`define SAR_MSB_IDX 3'h7
`define SAR_LSB_IDX 3'h0
`define SAR_IDX_STEP 3'h1

// reset values
`define SAR_RESULT_RST 8'h00
`define SAR_IDX_RST 3'h7
`define SAR_SYNC_RST 2'h0

// two-entry output buffer
`define SAR_BUF_CNT_W 2
`define SAR_BUF_FULL 2'h2
`define SAR_BUF_ONE 2'h1
`define SAR_BUF_EMPTY 2'h0

`endif

// ---- design/sar_pkg.sv ----
`include "sar_cfg.svh"

package sar_pkg;

    typedef logic [`SAR_WIDTH-1:0] sar_word_t;

    typedef logic [`SAR_IDX_W-1:0] sar_idx_t;

    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_RUN = 2'b01,
        SAR_DONE = 2'b10
    } sar_state_t;

    // one finished conversion as it travels through the buffer
    typedef struct packed {
        sar_word_t bits;
        logic shortened;
    } sar_result_t;

    // synchronised pin inputs
    typedef struct packed {
        logic trigger;
        logic comparator;
        logic master_clear;
    } sar_pins_t;

endpackage : sar_pkg

// ---- design/sar_buf.sv ----
`timescale 1ns/10ps
`include "sar_cfg.svh"

module sar_buf
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire sar_pkg::sar_result_t in_data_in,
    // draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output sar_pkg::sar_result_t out_data_out
);
    import sar_pkg::*;

    sar_result_t head_r;
    sar_result_t head_nxt;
    sar_result_t tail_r;
    sar_result_t tail_nxt;
    logic [`SAR_BUF_CNT_W-1:0] cnt_r;
    logic [`SAR_BUF_CNT_W-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_r != `SAR_BUF_FULL);
    assign out_valid_out = (cnt_r != `SAR_BUF_EMPTY);
    assign out_data_out = head_r;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        head_nxt = head_r;
        tail_nxt = tail_r;
        cnt_nxt = cnt_r;
        if (push && pop)
        begin
            if (cnt_r == `SAR_BUF_ONE)
                head_nxt = in_data_in;
            else
            begin
                head_nxt = tail_r;
                tail_nxt = in_data_in;
            end
        end
        else if (push)
        begin
            if (cnt_r == `SAR_BUF_EMPTY)
                head_nxt = in_data_in;
            else
                tail_nxt = in_data_in;
            cnt_nxt = cnt_r + `SAR_BUF_ONE;
        end
        else if (pop)
        begin
            head_nxt = tail_r;
            cnt_nxt = cnt_r - `SAR_BUF_ONE;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            head_r <= '0;
            tail_r <= '0;
            cnt_r <= `SAR_BUF_EMPTY;
        end
        else if (ce_in)
        begin
            head_r <= head_nxt;
            tail_r <= tail_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : sar_buf

// ---- design/sar_top.sv ----
`timescale 1ns/10ps
`include "sar_cfg.svh"

module sar_top
#(
    // 1: master-clear variant, 0: feed-forward variant
    parameter bit MASTER_CLEAR_VARIANT = 1'b1
)
(
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // control pins
    input wire logic conversion_trigger_in,
    input wire logic master_clear_in,
    input wire logic length_shortener_in,
    // comparator
    input wire logic comparator_in,
    // results towards the converter and the system
    output sar_pkg::sar_word_t parallel_result_bits_out,
    output logic serial_result_out,
    output logic conversion_done_out,
    output logic busy_out,
    // buffered result words
    output logic result_valid_out,
    input wire logic result_ready_in,
    output sar_pkg::sar_word_t result_word_out,
    output logic result_shortened_out
);
    import sar_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // word with one bit forced to a value
    function automatic sar_word_t sar_set_bit(input sar_word_t w, input sar_idx_t i,
                                              input logic v);
        sar_word_t r;
        r = w;
        r[i] = v;
        return r;
    endfunction : sar_set_bit

    // word with only the given bit high
    function automatic sar_word_t sar_one_hot(input sar_idx_t i);
        sar_word_t r;
        r = `SAR_RESULT_RST;
        r[i] = 1'b1;
        return r;
    endfunction : sar_one_hot

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    sar_pins_t meta_r;
    sar_pins_t meta_nxt;
    sar_pins_t pins_r;
    sar_pins_t pins_nxt;
    logic trig_prev_r;
    logic trig_prev_nxt;
    logic trig_rise;
    logic clear_active;

    sar_state_t state_r;
    sar_state_t state_nxt;
    sar_word_t result_r;
    sar_word_t result_nxt;
    sar_idx_t idx_r;
    sar_idx_t idx_nxt;
    logic serial_r;
    logic serial_nxt;
    logic done_r;
    logic done_nxt;
    logic done_fall_r;

    logic start_req;
    logic last_step;
    logic step_ok;
    sar_word_t decided;
    sar_result_t push_data;
    logic push_valid;
    logic push_ready;
    sar_result_t pop_data;

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for pin inputs

    always_comb
    begin
        meta_nxt.trigger = conversion_trigger_in;
        meta_nxt.comparator = comparator_in;
        meta_nxt.master_clear = MASTER_CLEAR_VARIANT ? master_clear_in : 1'b0;
        pins_nxt = meta_r;
        trig_prev_nxt = pins_r.trigger;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            meta_r <= '0;
            pins_r <= '0;
            trig_prev_r <= 1'b0;
        end
        else if (ce_in)
        begin
            meta_r <= meta_nxt;
            pins_r <= pins_nxt;
            trig_prev_r <= trig_prev_nxt;
        end
    end

    assign trig_rise = pins_r.trigger && !trig_prev_r;
    assign clear_active = MASTER_CLEAR_VARIANT && pins_r.master_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    // shortener comes from the cascade partner's outputs, so it needs no synchroniser
    assign last_step = (idx_r == `SAR_LSB_IDX) || (!MASTER_CLEAR_VARIANT && length_shortener_in);

    // the word being decided this cycle
    always_comb
    begin
        decided = sar_set_bit(result_r, idx_r, pins_r.comparator);
        if (idx_r != `SAR_LSB_IDX)
            decided = sar_set_bit(decided, idx_r - `SAR_IDX_STEP, 1'b1);
    end

    // the last step waits while the output buffer is full
    assign step_ok = !last_step || push_ready;

    always_comb
    begin
        start_req = 1'b0;
        case (state_r)
            SAR_IDLE:
                // feed-forward variant has no stable reset state
                start_req = !MASTER_CLEAR_VARIANT || pins_r.trigger;
            SAR_RUN:
                start_req = trig_rise;
            SAR_DONE:
                start_req = pins_r.trigger;
            default:
                start_req = 1'b0;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        result_nxt = result_r;
        idx_nxt = idx_r;
        serial_nxt = 1'b0;
        done_nxt = done_r;
        push_valid = 1'b0;
        push_data.bits = decided;
        push_data.shortened = (idx_r != `SAR_LSB_IDX);
        if (clear_active)
        begin
            state_nxt = SAR_IDLE;
            result_nxt = `SAR_RESULT_RST;
            idx_nxt = `SAR_IDX_RST;
            done_nxt = 1'b0;
        end
        else if (start_req)
        begin
            // first period: msb set, serial held inactive
            state_nxt = SAR_RUN;
            result_nxt = sar_one_hot(`SAR_MSB_IDX);
            idx_nxt = `SAR_MSB_IDX;
            done_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                SAR_IDLE:
                begin
                    state_nxt = SAR_IDLE;
                end
                SAR_RUN:
                begin
                    if (step_ok)
                    begin
                        result_nxt = decided;
                        serial_nxt = pins_r.comparator;
                        if (last_step)
                        begin
                            state_nxt = SAR_DONE;
                            done_nxt = 1'b1;
                            push_valid = 1'b1;
                        end
                        else
                            idx_nxt = idx_r - `SAR_IDX_STEP;
                    end
                    else
                        serial_nxt = serial_r;
                end
                SAR_DONE:
                begin
                    // decided bits hold, serial idles after done
                    state_nxt = SAR_DONE;
                end
                default:
                begin
                    state_nxt = SAR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            state_r <= SAR_IDLE;
            result_r <= `SAR_RESULT_RST;
            idx_r <= `SAR_IDX_RST;
            serial_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (ce_in)
        begin
            state_r <= state_nxt;
            result_r <= result_nxt;
            idx_r <= idx_nxt;
            serial_r <= serial_nxt;
            done_r <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // done flag, moved to the falling edge so the result bits settle first

    always_ff @(negedge ref_clk_in)
    begin
        if (!nrst_in)
            done_fall_r <= 1'b0;
        else if (ce_in)
            done_fall_r <= done_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry result buffer

    sar_buf u_buf
    (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .in_valid_in(push_valid && ce_in),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(result_valid_out),
        .out_ready_in(result_ready_in),
        .out_data_out(pop_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign parallel_result_bits_out = result_r;
    assign serial_result_out = serial_r;
    assign conversion_done_out = done_fall_r;
    assign busy_out = (state_r == SAR_RUN);
    assign result_word_out = pop_data.bits;
    assign result_shortened_out = pop_data.shortened;

endmodule : sar_top

// ---- sim/sar_cmp_model.sv ----
`timescale 1ns/10ps

module sar_cmp_model
(
    // converter word and analog level
    input wire sar_pkg::sar_word_t dac_in,
    input wire sar_pkg::sar_word_t level_in,
    // comparator bit
    output logic comparator_out
);
    import sar_pkg::*;
    // keep the trial bit while the level reaches the converter output
    assign comparator_out = (level_in >= dac_in);
endmodule : sar_cmp_model

// ---- sim/sar_chk_assertions.sv ----
`timescale 1ns/10ps

module sar_chk
#(
    parameter bit MASTER_CLEAR_VARIANT = 1'b1
)
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic master_clear_in,
    input wire sar_pkg::sar_word_t parallel_result_bits_out,
    input wire logic serial_result_out,
    input wire logic conversion_done_out,
    input wire logic busy_out,
    input wire logic result_valid_out
);
    import sar_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_start;
        $rose(busy_out);
    endsequence
    sequence s_steps;
        busy_out[*8];
    endsequence

    property p_clear_zero;
        master_clear_in[*4] |-> !MASTER_CLEAR_VARIANT || (parallel_result_bits_out == 8'h00
            && !busy_out && !serial_result_out && !conversion_done_out);
    endproperty
    property p_start_msb;
        s_start |-> parallel_result_bits_out == 8'h80;
    endproperty
    property p_start_quiet;
        s_start |-> !serial_result_out && !conversion_done_out;
    endproperty
    property p_run_len;
        s_start |-> s_steps ##1 (!busy_out || result_valid_out);
    endproperty
    property p_serial_msb;
        s_start |=> serial_result_out == parallel_result_bits_out[7];
    endproperty
    property p_done_rise;
        $rose(conversion_done_out) |-> $past(busy_out) && !busy_out;
    endproperty
    property p_serial_after_done;
        $rose(conversion_done_out) |=> !serial_result_out;
    endproperty
    property p_hold;
        (!busy_out && !master_clear_in)[*3] ##1 !busy_out |-> $stable(parallel_result_bits_out);
    endproperty

    a_clear_zero: assert property (p_clear_zero) else $error("clear left outputs set");
    a_start_msb: assert property (p_start_msb) else $error("start word wrong");
    a_start_quiet: assert property (p_start_quiet) else $error("start not quiet");
    a_run_len: assert property (p_run_len) else $error("step count wrong");
    a_serial_msb: assert property (p_serial_msb) else $error("serial not msb");
    a_done_rise: assert property (p_done_rise) else $error("done rose off last step");
    a_serial_after_done: assert property (p_serial_after_done) else $error("serial after done");
    a_hold: assert property (p_hold) else $error("result moved while idle");
endmodule : sar_chk

bind sar_top sar_chk #(.MASTER_CLEAR_VARIANT(MASTER_CLEAR_VARIANT)) chk_u (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .master_clear_in(master_clear_in),
    .parallel_result_bits_out(parallel_result_bits_out),
    .serial_result_out(serial_result_out),
    .conversion_done_out(conversion_done_out),
    .busy_out(busy_out),
    .result_valid_out(result_valid_out)
);

// ---- sim/sar_top_test.sv ----
`timescale 1ns/10ps

module sar_top_test;
    import sar_pkg::*;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic trig = 1'b0;
    logic clr = 1'b0;
    logic ready = 1'b0;
    logic cmp;
    logic done_q = 1'b0;
    sar_word_t level = 8'hff;
    sar_word_t par;
    sar_word_t word;
    logic ser, done, busy, valid, short;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    int ones = 0;
    int gap = 0;
    int last_rise = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    sar_top dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .conversion_trigger_in(trig), .master_clear_in(clr),
        // single full-length stage: no shortening, no cascade partner
        .length_shortener_in(1'b0), .comparator_in(cmp),
        .parallel_result_bits_out(par), .serial_result_out(ser),
        .conversion_done_out(done), .busy_out(busy), .result_valid_out(valid),
        .result_ready_in(ready), .result_word_out(word), .result_shortened_out(short));
    sar_cmp_model cmp_u (.dac_in(par), .level_in(level), .comparator_out(cmp));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step

    // start pulse kept well under one conversion
    task automatic convert(input sar_word_t lvl);
        int k;
        ones = 0;
        @(posedge ref_clk_in);
        level <= lvl;
        trig <= 1'b1;
        step(3);
        @(posedge ref_clk_in);
        trig <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40)
        begin
            step(1);
            k++;
        end
        step(2);
    endtask : convert

    task automatic pop(input sar_word_t exp);
        check("valid", 8'(valid), 8'h01);
        check("word", word, exp);
        check("shortened", 8'(short), 8'h00);
        @(posedge ref_clk_in);
        ready <= 1'b1;
        @(posedge ref_clk_in);
        ready <= 1'b0;
        step(1);
    endtask : pop

    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (ser === 1'b1)
            ones <= ones + 1;
        if (done === 1'b1 && done_q === 1'b0)
        begin
            gap <= cycles - last_rise;
            last_rise <= cycles;
        end
        done_q <= done;
        if (cycles == 3000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        step(20);
        check("idle busy", 8'(busy), 8'h00);
        check("idle word", par, 8'h00);
        $display("test idle ended");
        convert(8'hff);
        check("word high", par, 8'hff);
        check("serial ones", 8'(ones), 8'h08);
        step(10);
        check("held word", par, 8'hff);
        pop(8'hff);
        convert(8'h00);
        check("word low", par, 8'h00);
        check("serial zeros", 8'(ones), 8'h00);
        pop(8'h00);
        $display("test conversions ended");
        convert(8'hff);
        pop(8'hff);
        @(posedge ref_clk_in);
        clr <= 1'b1;
        step(4);
        check("cleared word", par, 8'h00);
        check("cleared done", 8'(done), 8'h00);
        @(posedge ref_clk_in);
        clr <= 1'b0;
        step(10);
        check("stays reset", 8'(busy), 8'h00);
        $display("test clear ended");
        @(posedge ref_clk_in);
        level <= 8'hff;
        trig <= 1'b1;
        step(25);
        check("restart gap", 8'(gap), 8'h09);
        step(40);
        check("stalled busy", 8'(busy), 8'h01);
        @(posedge ref_clk_in);
        trig <= 1'b0;
        // let the edge settle before looking at the buffer
        #1;
        pop(8'hff);
        pop(8'hff);
        step(4);
        pop(8'hff);
        $display("test free run ended");
        give_verdict();
    end
endmodule : sar_top_test
